// ===== smps_pkg.sv
// package for the stop mode power sequencer
package smps_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    SMPS_RUN      = 3'b000,
    SMPS_DEEP     = 3'b001,
    SMPS_RETAIN   = 3'b010,
    SMPS_WAKE_POR = 3'b011,
    SMPS_WAKE_INT = 3'b100
  } smps_state_t;

  // wake source bundle, synchronised before use
  typedef struct packed {
    logic reset_pin_n;
    logic irq_pin_n;
    logic periodic_wake_interrupt;
    logic lowvolt_irq;
    logic converter_irq;
    logic keypad_interrupt;
    logic debug_background_cmd;
  } smps_wake_t;

  // power and clock controls driven out
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic debug_clk_en;
    logic core_power_en;
    logic regulator_standby;
    logic converter_standby;
    logic pin_latch_hold;
    logic irq_force_active_low;
  } smps_ctrl_t;

  // run values: clocks on, core powered, full regulation, latches open
  localparam smps_ctrl_t SMPS_CTRL_RST = 8'hf0;
  // pins released high, no interrupt pending
  localparam smps_wake_t SMPS_WAKE_IDLE = 7'h60;
  localparam logic SMPS_FLAG_RST = 1'b0;
  localparam logic [1:0] SMPS_STATUS_RUN = 2'h0;
  localparam logic [1:0] SMPS_STATUS_DEEP = 2'h1;
  localparam logic [1:0] SMPS_STATUS_RETAIN = 2'h2;
  localparam logic [1:0] SMPS_DBG_OK = 2'h0;
  localparam logic [1:0] SMPS_DBG_ERR_STOPPED = 2'h2;
  localparam int SMPS_SYNC_STAGES = 2;

  typedef struct packed {
    smps_state_t state;
    smps_ctrl_t ctrl;
    logic powerdown_wake_flag;
    logic illegal_op_reset;
    logic por_request;
    logic irq_vector_fetch;
    logic debug_active;
    logic [1:0] mode_status;
    logic [1:0] dbg_status;
    logic dbg_status_valid;
    logic converter_run;
    logic [SMPS_SYNC_STAGES-1:0][$bits(smps_wake_t)-1:0] sync;
  } smps_reg_t;
endpackage : smps_pkg

// ===== smps_stop_sequencer.sv
// stop mode power sequencer: mode select, clock gating, pin latch, wake
`timescale 1ns/1ps
module smps_stop_sequencer
  import smps_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic stop_instr,
  input wire logic stop_instr_enable,
  input wire logic partial_powerdown_select,
  input wire logic lowvolt_detect_enable,
  input wire logic lowvolt_stop_enable,
  input wire logic debug_mode_enable,
  input wire logic converter_async_clk_en,
  input wire logic powerdown_ack_wr,
  input wire logic powerdown_ack_data,
  input wire logic dbg_status_cmd,
  input wire smps_wake_t wake_in,
  output smps_ctrl_t ctrl,
  output logic powerdown_wake_flag,
  output logic powerdown_ack,
  output logic illegal_op_reset,
  output logic por_request,
  output logic irq_vector_fetch,
  output logic debug_active,
  output logic converter_run,
  output logic [1:0] mode_status,
  output logic [1:0] dbg_status,
  output logic dbg_status_valid
);
  smps_reg_t r;
  smps_reg_t next_r;
  smps_wake_t w;
  logic lvd_in_stop;
  logic ack_one;

  assign w = smps_wake_t'(r.sync[SMPS_SYNC_STAGES-1]);
  assign lvd_in_stop = lowvolt_detect_enable & lowvolt_stop_enable;
  assign ack_one = powerdown_ack_wr & powerdown_ack_data;

  always_comb begin
    next_r = r;
    next_r.sync[0] = wake_in;
    next_r.sync[1] = r.sync[0];
    next_r.illegal_op_reset = 1'b0;
    next_r.por_request = 1'b0;
    next_r.irq_vector_fetch = 1'b0;
    next_r.dbg_status_valid = 1'b0;
    if (ack_one) begin
      next_r.ctrl.pin_latch_hold = 1'b0;
      next_r.powerdown_wake_flag = 1'b0;
    end
    case (r.state)
      SMPS_RUN: begin
        next_r.ctrl = SMPS_CTRL_RST;
        next_r.ctrl.pin_latch_hold = ack_one ? 1'b0 : r.ctrl.pin_latch_hold;
        next_r.mode_status = SMPS_STATUS_RUN;
        next_r.converter_run = 1'b1;
        if (!w.debug_background_cmd) begin
          next_r.debug_active = r.debug_active;
        end
        if (stop_instr && !stop_instr_enable) begin
          next_r.illegal_op_reset = 1'b1;
        end else if (stop_instr) begin
          next_r.ctrl.cpu_clk_en = 1'b0;
          next_r.ctrl.periph_clk_en = 1'b0;
          next_r.ctrl.debug_clk_en = debug_mode_enable;
          if (partial_powerdown_select && !lvd_in_stop
              && !debug_mode_enable) begin
            next_r.state = SMPS_DEEP;
            next_r.mode_status = SMPS_STATUS_DEEP;
            next_r.ctrl.core_power_en = 1'b0;
            next_r.ctrl.regulator_standby = 1'b1;
            next_r.ctrl.converter_standby = 1'b1;
            next_r.ctrl.pin_latch_hold = 1'b1;
            next_r.ctrl.irq_force_active_low = 1'b1;
            next_r.converter_run = 1'b0;
          end else begin
            next_r.state = SMPS_RETAIN;
            next_r.mode_status = SMPS_STATUS_RETAIN;
            // full regulation kept for debug or lvd
            next_r.ctrl.regulator_standby =
              !(debug_mode_enable || lvd_in_stop);
            next_r.converter_run =
              converter_async_clk_en & lvd_in_stop;
            next_r.ctrl.converter_standby =
              !(converter_async_clk_en & lvd_in_stop);
          end
        end
      end
      SMPS_DEEP: begin
        // only pins and the periodic timer can wake
        if (!w.reset_pin_n || !w.irq_pin_n
            || w.periodic_wake_interrupt) begin
          next_r.state = SMPS_WAKE_POR;
        end
      end
      SMPS_RETAIN: begin
        if (!w.reset_pin_n) begin
          next_r.state = SMPS_WAKE_POR;
        end else if (debug_mode_enable && w.debug_background_cmd) begin
          next_r.state = SMPS_RUN;
          next_r.debug_active = 1'b1;
        end else if (w.periodic_wake_interrupt || w.lowvolt_irq
                     || w.converter_irq || !w.irq_pin_n
                     || w.keypad_interrupt) begin
          next_r.state = SMPS_WAKE_INT;
        end
      end
      SMPS_WAKE_POR: begin
        // restart as from power-on; latch stays closed
        next_r.por_request = 1'b1;
        next_r.debug_active = 1'b0;
        if (r.mode_status == SMPS_STATUS_DEEP) begin
          next_r.powerdown_wake_flag = 1'b1;
        end
        next_r.state = SMPS_RUN;
      end
      SMPS_WAKE_INT: begin
        next_r.irq_vector_fetch = 1'b1;
        next_r.state = SMPS_RUN;
      end
      default: begin
        next_r.state = SMPS_RUN;
      end
    endcase
    // status command while stopped: no access, error
    if (dbg_status_cmd) begin
      next_r.dbg_status_valid = 1'b1;
      next_r.dbg_status = (r.state == SMPS_DEEP || r.state == SMPS_RETAIN)
                          ? SMPS_DBG_ERR_STOPPED : SMPS_DBG_OK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r <= '0;
      r.state <= SMPS_RUN;
      r.ctrl <= SMPS_CTRL_RST;
      r.powerdown_wake_flag <= SMPS_FLAG_RST;
      r.converter_run <= 1'b1;
      // idle levels, so no false wake shows right after reset
      r.sync <= {SMPS_SYNC_STAGES{SMPS_WAKE_IDLE}};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign ctrl = r.ctrl;
  assign powerdown_wake_flag = r.powerdown_wake_flag;
  assign powerdown_ack = 1'b0;
  assign illegal_op_reset = r.illegal_op_reset;
  assign por_request = r.por_request;
  assign irq_vector_fetch = r.irq_vector_fetch;
  assign debug_active = r.debug_active;
  assign converter_run = r.converter_run;
  assign mode_status = r.mode_status;
  assign dbg_status = r.dbg_status;
  assign dbg_status_valid = r.dbg_status_valid;
endmodule : smps_stop_sequencer

// ===== smps_assertions.sv
// checker for the stop mode power sequencer
`timescale 1ns/1ps
module smps_chk
  import smps_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic stop_instr,
  input wire logic stop_instr_enable,
  input wire logic partial_powerdown_select,
  input wire logic lowvolt_detect_enable,
  input wire logic lowvolt_stop_enable,
  input wire logic debug_mode_enable,
  input wire logic powerdown_ack_wr,
  input wire logic powerdown_ack_data,
  input wire logic dbg_status_cmd,
  input wire smps_ctrl_t ctrl,
  input wire logic powerdown_wake_flag,
  input wire logic powerdown_ack,
  input wire logic illegal_op_reset,
  input wire logic por_request,
  input wire logic [1:0] mode_status,
  input wire logic [1:0] dbg_status,
  input wire logic dbg_status_valid
);
  // cpu clock on is taken as run state, stop requests count only there
  wire go = stop_instr && clk_en && ctrl.cpu_clk_en && stop_instr_enable;
  wire lv = lowvolt_detect_enable && lowvolt_stop_enable;
  wire ackw = powerdown_ack_wr && powerdown_ack_data;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  stop_refuse_a: assert property (stop_instr && clk_en && ctrl.cpu_clk_en &&
    !stop_instr_enable |=> illegal_op_reset) else $error("no illegal reset");
  deep_entry_a: assert property (go && partial_powerdown_select && !lv &&
    !debug_mode_enable |=> mode_status == SMPS_STATUS_DEEP &&
    ctrl.pin_latch_hold && !ctrl.core_power_en) else $error("deep entry");
  retain_sel_a: assert property (go && (!partial_powerdown_select || lv ||
    debug_mode_enable) |=> mode_status == SMPS_STATUS_RETAIN)
    else $error("retention select");
  debug_keep_a: assert property (go && debug_mode_enable |=>
    ctrl.debug_clk_en && !ctrl.regulator_standby) else $error("debug clk");
  periph_stop_a: assert property (!ctrl.cpu_clk_en |->
    !ctrl.periph_clk_en) else $error("periph clock runs");
  ack_zero_a: assert property (powerdown_ack == 1'b0) else $error("ack read");
  flag_hold_a: assert property (powerdown_wake_flag && !ackw |=>
    powerdown_wake_flag) else $error("flag lost");
  latch_release_a: assert property ($fell(ctrl.pin_latch_hold)
    |-> $past(ackw)) else $error("latch open");
  dbg_err_a: assert property (dbg_status_cmd && clk_en && !ctrl.cpu_clk_en
    |=> dbg_status_valid ##0 dbg_status == SMPS_DBG_ERR_STOPPED)
    else $error("debug status");
  c_deep: cover property (go ##1 mode_status == SMPS_STATUS_DEEP);
  c_por: cover property (por_request && powerdown_wake_flag);
  c_ill: cover property (illegal_op_reset);
endmodule : smps_chk
bind smps_stop_sequencer smps_chk chk (.*);

// ===== smps_stop_sequencer_test.sv
// self-checking bench for the stop mode power sequencer
`timescale 1ns/1ps
module smps_stop_sequencer_test import smps_pkg::*;;
  logic mclk = 0, resetn = 0, clk_en = 1, stop_instr = 0, stop_instr_enable = 0;
  logic partial_powerdown_select = 0, lowvolt_detect_enable = 0;
  logic lowvolt_stop_enable = 0, debug_mode_enable = 0, dbg_status_cmd = 0;
  logic converter_async_clk_en = 0, powerdown_ack_wr = 0, powerdown_ack_data = 0;
  smps_wake_t wake_in = 7'h60;
  smps_ctrl_t ctrl;
  logic powerdown_wake_flag, powerdown_ack, illegal_op_reset, por_request;
  logic irq_vector_fetch, debug_active, converter_run, dbg_status_valid;
  logic [1:0] mode_status, dbg_status, em;
  logic [31:0] seed = 32'h4564b482;
  logic [4:0] r;
  int n_errors = 0, num_checks = 0;
  always #5 mclk = ~mclk;
  smps_stop_sequencer dut (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // v holds enable, select, lvd on, lvd in stop, debug
  function automatic logic [1:0] exp_mode(input logic [4:0] v);
    return (v[3] && !(v[2] && v[1]) && !v[0]) ? SMPS_STATUS_DEEP
      : SMPS_STATUS_RETAIN;
  endfunction : exp_mode
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // bounded wait for the one-cycle wake answer
  task automatic wait_hit(input bit vec);
    for (int k = 0; k < 10; k++) begin
      @(posedge mclk);
      #1;
      if ((vec ? irq_vector_fetch : por_request) === 1'b1) return;
    end
    chk("wake", 0, 1);
  endtask : wait_hit
  task automatic ack(input logic d);
    @(posedge mclk);
    wake_in <= 7'h60;
    powerdown_ack_wr <= 1;
    powerdown_ack_data <= d;
    @(posedge mclk);
    powerdown_ack_wr <= 0;
    #1;
  endtask : ack
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1;
    #1;
    chk("ctrl rst", ctrl, SMPS_CTRL_RST);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      r = (i < 32) ? i[4:0] : seed[4:0];
      @(posedge mclk);
      {stop_instr_enable, partial_powerdown_select, lowvolt_detect_enable,
        lowvolt_stop_enable, debug_mode_enable} <= r;
      converter_async_clk_en <= seed[8];
      stop_instr <= 1;
      @(posedge mclk);
      stop_instr <= 0;
      #1;
      em = exp_mode(r);
      if (!r[4]) chk("illegal", illegal_op_reset, 1);
      else begin
        chk("mode", mode_status, em);
        chk("clocks", {ctrl.cpu_clk_en, ctrl.periph_clk_en}, 0);
        chk("reg", ctrl.regulator_standby, !(r[0] || (r[2] && r[1])));
        chk("conv", converter_run,
            em == SMPS_STATUS_RETAIN && seed[8] && r[2] && r[1]);
        @(posedge mclk);
        dbg_status_cmd <= 1;
        @(posedge mclk);
        dbg_status_cmd <= 0;
        #1;
        chk("dbg", {dbg_status_valid, dbg_status}, 3'h6);
        @(posedge mclk);
        if (em == SMPS_STATUS_DEEP) wake_in.irq_pin_n <= 0;
        else wake_in.keypad_interrupt <= 1;
        wait_hit(em != SMPS_STATUS_DEEP);
        chk("flag", powerdown_wake_flag, em == SMPS_STATUS_DEEP);
        chk("held", ctrl.pin_latch_hold, em == SMPS_STATUS_DEEP);
        ack(seed[9]);
        chk("ack", powerdown_wake_flag, em == SMPS_STATUS_DEEP && !seed[9]);
        ack(1);
        chk("open", {powerdown_wake_flag, ctrl.pin_latch_hold}, 0);
      end
      repeat (4) @(posedge mclk);
    end
    // background command wakes a debug-enabled retention stop
    @(posedge mclk);
    {stop_instr_enable, partial_powerdown_select, lowvolt_detect_enable,
      lowvolt_stop_enable, debug_mode_enable} <= 5'h19;
    stop_instr <= 1;
    @(posedge mclk);
    stop_instr <= 0;
    @(posedge mclk);
    wake_in.debug_background_cmd <= 1;
    repeat (4) @(posedge mclk);
    #1;
    chk("debug", debug_active, 1);
    @(posedge mclk);
    wake_in <= 7'h60;
    repeat (4) @(posedge mclk);
    end_sim;
  end
endmodule : smps_stop_sequencer_test
